// file: design/hbg_pkg.sv
// Package with constants and types for the H-bridge gate control block.
package hbg_pkg;
  localparam int unsigned CLK_HZ         = 200_000_000;
  localparam int unsigned CHOP_DIV       = 8;
  localparam logic [2:0]  CHOP_LAST      = 3'h7;
  localparam logic [2:0]  CHOP_ZERO      = 3'h0;
  localparam int unsigned DEAD_NS        = 50;
  localparam int unsigned DEAD_CYC_RAW   = (DEAD_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int unsigned DEAD_CYC       = (DEAD_CYC_RAW < 1) ? 1 : DEAD_CYC_RAW;
  localparam logic [3:0]  DEAD_CNT       = 4'(DEAD_CYC);
  localparam logic [3:0]  CUR_ZERO       = 4'h0;
  localparam logic [3:0]  GATES_OFF      = 4'h0;
  localparam logic [2:0]  DEFAULT_FAST_AT = 3'h5;

  typedef enum logic [3:0] {
    HBG_OFF    = 4'b0001,
    HBG_CHARGE = 4'b0010,
    HBG_SLOW   = 4'b0100,
    HBG_FAST   = 4'b1000
  } hbg_mode_t;

  typedef enum logic [2:0] {
    HBG_PUMP_IDLE = 3'b001,
    HBG_PUMP_FILL = 3'b010,
    HBG_PUMP_MOVE = 3'b100
  } hbg_pump_t;
endpackage

// file: design/hbg_pump.sv
// Charge pump switch sequencer for the boosted gate rail.
`timescale 1ns/1ps
module hbg_pump (
  input  wire logic clk_i,
  input  wire logic rstn_i,
  input  wire logic run_i,
  input  wire logic restart_i,
  input  wire logic osc_tick_i,
  input  wire logic rail_ok_i,
  output logic      pump_switch_first_o,
  output logic      pump_switch_second_o
);
  import hbg_pkg::*;
  hbg_pump_t state_q;

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_q <= HBG_PUMP_IDLE;
    end else if (!run_i || restart_i) begin
      state_q <= run_i ? HBG_PUMP_FILL : HBG_PUMP_IDLE;
    end else if (osc_tick_i) begin
      case (state_q)
        HBG_PUMP_IDLE: state_q <= rail_ok_i ? HBG_PUMP_IDLE : HBG_PUMP_FILL;
        HBG_PUMP_FILL: state_q <= HBG_PUMP_MOVE;
        HBG_PUMP_MOVE: state_q <= rail_ok_i ? HBG_PUMP_IDLE : HBG_PUMP_FILL;
        default:       state_q <= HBG_PUMP_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pump_switch_first_o  <= 1'b0;
      pump_switch_second_o <= 1'b0;
    end else begin
      pump_switch_first_o  <= (state_q == HBG_PUMP_FILL);
      pump_switch_second_o <= (state_q == HBG_PUMP_MOVE);
    end
  end

  a_pump_exclusive: assert property (@(posedge clk_i) disable iff (!rstn_i)
    !(pump_switch_first_o && pump_switch_second_o)) else $error("pump switches both on");
  a_pump_order: assert property (@(posedge clk_i) disable iff (!rstn_i)
    $rose(pump_switch_second_o) |-> $past(pump_switch_first_o, 1)) else $error("pump move without fill");
  a_pump_stop: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (run_i && !restart_i && osc_tick_i && rail_ok_i && state_q == HBG_PUMP_MOVE) |=> ##1 !pump_switch_first_o
    && !pump_switch_second_o) else $error("pump did not stop at full rail");
endmodule

// file: design/hbg_ctrl.sv
// Gate control for one H-bridge phase with decay sequencing, reset and pump.
`timescale 1ns/1ps
module hbg_ctrl (
  input  wire logic       clk_i,
  input  wire logic       rstn_i,
  input  wire logic       reset_in_n_i,
  input  wire logic       logic_supply_ok_i,
  input  wire logic       motor_supply_ok_i,
  input  wire logic       thermal_shutdown_i,
  input  wire logic       overcurrent_shutdown_i,
  input  wire logic       chop_osc_clock_i,
  input  wire logic       strobe_i,
  input  wire logic       phase_i,
  input  wire logic [3:0] current_i,
  input  wire logic       mixed_decay_i,
  input  wire logic [2:0] decay_ratio_setting_i,
  input  wire logic       current_reached_i,
  input  wire logic       rail_full_i,
  output logic            high_side_left_o,
  output logic            high_side_right_o,
  output logic            low_side_left_o,
  output logic            low_side_right_o,
  output logic            pump_switch_first_o,
  output logic            pump_switch_second_o,
  output logic            int_reset_o,
  output logic [2:0]      chop_count_o
);
  import hbg_pkg::*;

  logic       run;
  logic       shutdown;
  logic       osc_q;
  logic       tick;
  logic       strobe_pend_q;
  logic       zero_q;
  logic       run_q;
  logic       restart;
  logic [3:0] dead_q;
  logic [3:0] gates_d;
  logic [3:0] gates_prev_q;
  hbg_mode_t  mode_q;
  hbg_mode_t  mode_d;

  assign shutdown = thermal_shutdown_i | overcurrent_shutdown_i;
  assign run      = reset_in_n_i & logic_supply_ok_i & motor_supply_ok_i & !shutdown;
  assign tick     = chop_osc_clock_i & !osc_q;
  assign restart  = run & !run_q;

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      osc_q <= 1'b0;
      run_q <= 1'b0;
    end else begin
      osc_q <= chop_osc_clock_i;
      run_q <= run;
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      int_reset_o <= 1'b1;
    end else begin
      int_reset_o <= !run;
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      strobe_pend_q <= 1'b0;
      chop_count_o  <= CHOP_ZERO;
    end else if (!run) begin
      strobe_pend_q <= 1'b0;
      chop_count_o  <= CHOP_ZERO;
    end else begin
      if (strobe_i) begin
        strobe_pend_q <= 1'b1;
      end else if (tick) begin
        strobe_pend_q <= 1'b0;
      end
      if (tick) begin
        if (strobe_pend_q) begin
          chop_count_o <= CHOP_ZERO;
        end else begin
          chop_count_o <= (chop_count_o == CHOP_LAST) ? CHOP_ZERO : chop_count_o + 3'h1;
        end
      end
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      zero_q <= 1'b1;
    end else if (strobe_i) begin
      zero_q <= (current_i == CUR_ZERO);
    end
  end

  always_comb begin
    mode_d = mode_q;
    if (!run || zero_q) begin
      mode_d = HBG_OFF;
    end else if (tick) begin
      if (chop_count_o == CHOP_LAST || strobe_pend_q) begin
        mode_d = HBG_CHARGE;
      end else begin
        case (mode_q)
          HBG_OFF:    mode_d = HBG_CHARGE;
          HBG_CHARGE: mode_d = current_reached_i ? HBG_SLOW : HBG_CHARGE;
          HBG_SLOW: begin
            if (mixed_decay_i && chop_count_o >= decay_ratio_setting_i) begin
              mode_d = HBG_FAST;
            end
          end
          HBG_FAST:   mode_d = HBG_FAST;
          default:    mode_d = HBG_OFF;
        endcase
      end
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      mode_q <= HBG_OFF;
    end else begin
      mode_q <= mode_d;
    end
  end

  always_comb begin
    case (mode_q)
      HBG_CHARGE: gates_d = phase_i ? 4'b1001 : 4'b0110;
      HBG_SLOW:   gates_d = 4'b0011;
      HBG_FAST:   gates_d = phase_i ? 4'b0110 : 4'b1001;
      default:    gates_d = GATES_OFF;
    endcase
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      gates_prev_q <= GATES_OFF;
      dead_q       <= 4'h0;
    end else if (gates_d != gates_prev_q) begin
      gates_prev_q <= gates_d;
      dead_q       <= DEAD_CNT;
    end else if (dead_q != 4'h0) begin
      dead_q <= dead_q - 4'h1;
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      high_side_left_o  <= 1'b0;
      high_side_right_o <= 1'b0;
      low_side_left_o   <= 1'b0;
      low_side_right_o  <= 1'b0;
    end else if (!run || zero_q || gates_d != gates_prev_q || dead_q != 4'h0) begin
      high_side_left_o  <= 1'b0;
      high_side_right_o <= 1'b0;
      low_side_left_o   <= 1'b0;
      low_side_right_o  <= 1'b0;
    end else begin
      high_side_left_o  <= gates_prev_q[3];
      high_side_right_o <= gates_prev_q[2];
      low_side_left_o   <= gates_prev_q[1];
      low_side_right_o  <= gates_prev_q[0];
    end
  end

  hbg_pump u_pump (
    .clk_i                (clk_i),
    .rstn_i               (rstn_i),
    .run_i                (run),
    .restart_i            (restart),
    .osc_tick_i           (tick),
    .rail_ok_i            (rail_full_i),
    .pump_switch_first_o  (pump_switch_first_o),
    .pump_switch_second_o (pump_switch_second_o)
  );

  a_half_left: assert property (@(posedge clk_i) disable iff (!rstn_i)
    !(high_side_left_o && low_side_left_o)) else $error("left half-bridge shoot-through");
  a_half_right: assert property (@(posedge clk_i) disable iff (!rstn_i)
    !(high_side_right_o && low_side_right_o)) else $error("right half-bridge shoot-through");
  a_zero_off: assert property (@(posedge clk_i) disable iff (!rstn_i)
    zero_q |=> !high_side_left_o && !high_side_right_o && !low_side_left_o && !low_side_right_o)
    else $error("zero current not off");
  a_reset_off: assert property (@(posedge clk_i) disable iff (!rstn_i)
    !logic_supply_ok_i |=> int_reset_o && !high_side_left_o && !high_side_right_o && !low_side_left_o
    && !low_side_right_o)
    else $error("outputs on without logic supply");
  a_motor_reset: assert property (@(posedge clk_i) disable iff (!rstn_i)
    !motor_supply_ok_i |=> int_reset_o) else $error("motor undervoltage not reset");
  a_slow_gates: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (mode_q == HBG_SLOW) && $stable(mode_q) && run && !zero_q && dead_q == 4'h0 && $past(dead_q) == 4'h0
    |=> low_side_left_o && low_side_right_o) else $error("slow decay gates wrong");
  a_charge_ref: assert property (@(posedge clk_i) disable iff (!rstn_i)
    high_side_left_o && low_side_right_o |-> $past(gates_prev_q) == 4'b1001) else $error("bad charge pair");
  a_mode_order: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (mode_q == HBG_FAST) && $changed(mode_q) |-> $past(mode_q) == HBG_SLOW) else $error("fast not after slow");
  a_strobe_reset: assert property (@(posedge clk_i) disable iff (!rstn_i)
    run && strobe_pend_q && tick |=> chop_count_o == CHOP_ZERO || !run) else $error("strobe no count reset");
  a_dead_gap: assert property (@(posedge clk_i) disable iff (!rstn_i)
    gates_d != gates_prev_q |=> !high_side_left_o && !high_side_right_o) else $error("no dead gap");
endmodule

// file: verif/hbg_coil_model.sv
// Behavioural bridge switches, coil current and boosted rail.
`timescale 1ns/1ps
module hbg_coil_model (
  input  wire logic       clk_i,
  input  wire logic [3:0] gates_i,
  input  wire logic       pump_second_i,
  output logic            reached_o,
  output logic            rail_full_o,
  output logic            shoot_o
);
  int   cur_q;
  int   pumps_q;
  logic sec_q;
  initial begin
    cur_q = 0;
    pumps_q = 0;
    sec_q = 1'b0;
  end
  always @(posedge clk_i) begin
    sec_q <= pump_second_i;
    if (pump_second_i && !sec_q) pumps_q <= pumps_q + 1;
    if (gates_i == 4'b1001) cur_q <= cur_q + 2;
    else if (gates_i == 4'b0110 && cur_q <= 0) cur_q <= cur_q - 2;
    else if (gates_i == 4'b0011) cur_q <= cur_q;
    else if (cur_q > 0) cur_q <= cur_q - 1;
    else if (cur_q < 0) cur_q <= cur_q + 1;
  end
  assign reached_o = (cur_q >= 40) || (cur_q <= -40);
  assign rail_full_o = (pumps_q >= 3);
  assign shoot_o = (gates_i[3] & gates_i[1]) | (gates_i[2] & gates_i[0]);
endmodule

// file: verif/tb.sv
// Self-checking bench for the H-bridge gate control block.
`timescale 1ns/1ps
`define CHK(nm, e, s) begin n_checks++; if ((e) !== (s)) begin bad_count++; \
  $display("MISMATCH %s exp %0h got %0h", nm, e, s); end end
module tb;
  logic       clk_i = 0, rstn_i = 0, osc = 0, strobe_i = 0, phase_i = 1;
  logic       mixed_decay_i = 1;
  logic [4:0] fault = 5'h00;
  logic [3:0] current_i = 4'h0;
  logic [2:0] decay_ratio_setting_i = 3'h4;
  logic       hl, hr, ll, lr, pf, ps, ir, reached, full, shoot;
  logic [2:0] cnt;
  logic [3:0] g, p, c, f;
  logic [9:0] obs;
  int         bad_count = 0, n_checks = 0, cyc = 0;
  assign g = {hl, hr, ll, lr};
  assign obs = {g, pf, ps, ir, cnt};
  hbg_ctrl dut (.clk_i(clk_i), .rstn_i(rstn_i), .reset_in_n_i(~fault[0]), .logic_supply_ok_i(~fault[1]),
    .motor_supply_ok_i(~fault[2]), .thermal_shutdown_i(fault[3]), .overcurrent_shutdown_i(fault[4]),
    .chop_osc_clock_i(osc), .strobe_i(strobe_i), .phase_i(phase_i), .current_i(current_i),
    .mixed_decay_i(mixed_decay_i), .decay_ratio_setting_i(decay_ratio_setting_i),
    .current_reached_i(reached), .rail_full_i(full), .high_side_left_o(hl), .high_side_right_o(hr),
    .low_side_left_o(ll), .low_side_right_o(lr), .pump_switch_first_o(pf), .pump_switch_second_o(ps),
    .int_reset_o(ir), .chop_count_o(cnt));
  hbg_coil_model coil (.clk_i(clk_i), .gates_i(g), .pump_second_i(ps), .reached_o(reached),
    .rail_full_o(full), .shoot_o(shoot));
  always #2.5 clk_i = ~clk_i;
  always begin
    repeat (20) @(posedge clk_i);
    #1 osc = ~osc;
  end
  always @(negedge clk_i) if (rstn_i && shoot !== 1'b0) `CHK("shoot", 1'b0, shoot)
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 30000) begin
      bad_count++;
      final_report();
    end
  end
  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic wait_m(input logic [9:0] m, input logic [9:0] e, input int lim, input string nm);
    int i;
    i = 0;
    while ((obs & m) !== e && i < lim) begin
      @(posedge clk_i);
      #1 i++;
    end
    `CHK(nm, e, obs & m)
  endtask
  task automatic next_pat(input logic [3:0] prev, output logic [3:0] got);
    int i;
    i = 0;
    got = g;
    while ((got === prev || got === 4'h0) && i < 900) begin
      @(posedge clk_i);
      #1 got = g;
      i++;
    end
  endtask
  task automatic strobe(input logic [3:0] v);
    current_i = v;
    strobe_i = 1'b1;
    @(posedge clk_i);
    #1 strobe_i = 1'b0;
  endtask
  initial begin
    repeat (6) @(posedge clk_i);
    #1 `CHK("reset", 10'h008, obs)
    rstn_i = 1'b1;
    repeat (400) @(posedge clk_i);
    #1 $display("test reset done");
    for (int d = 1; d >= 0; d--) begin
      phase_i = d[0];
      c = d ? 4'b1001 : 4'b0110;
      f = d ? 4'b0110 : 4'b1001;
      strobe(4'hF);
      wait_m(10'h3C0, {c, 6'h00}, 900, "charge");
      next_pat(c, p);
      `CHK("slow", 4'b0011, p)
      next_pat(4'b0011, p);
      `CHK("fast", f, p)
      next_pat(f, p);
      `CHK("recharge", c, p)
      $display("test direction %0d done", d);
    end
    wait_m(10'h007, 10'h003, 330, "cnt3");
    repeat (40) @(posedge clk_i);
    #1 `CHK("cnt step", 3'h4, cnt)
    repeat (280) @(posedge clk_i);
    #1 `CHK("cnt wrap", 3'h3, cnt)
    strobe(4'hF);
    wait_m(10'h007, 10'h000, 45, "cnt clear");
    $display("test counter done");
    mixed_decay_i = 1'b0;
    strobe(4'hF);
    wait_m(10'h3C0, {c, 6'h00}, 900, "slow only charge");
    next_pat(c, p);
    `CHK("slow only", 4'b0011, p)
    next_pat(4'b0011, p);
    `CHK("slow to charge", c, p)
    mixed_decay_i = 1'b1;
    $display("test slow decay done");
    strobe(4'h0);
    wait_m(10'h3C0, 10'h000, 60, "zero off");
    p = 4'h0;
    repeat (400) begin
      @(posedge clk_i);
      #1 p = p | g;
    end
    `CHK("zero stays off", 4'h0, p)
    $display("test zero current done");
    strobe(4'hF);
    for (int k = 0; k < 5; k++) begin
      fault = 5'h01 << k;
      wait_m(10'h3F8, 10'h008, 8, "int reset");
      repeat (50) @(posedge clk_i);
      #1 `CHK("held off", 10'h008, obs & 10'h3F8)
      fault = 5'h00;
      wait_m(10'h038, 10'h020, 10, "pump first");
      wait_m(10'h038, 10'h010, 60, "pump second");
      wait_m(10'h030, 10'h000, 60, "pump rest");
    end
    $display("test supervision done");
    final_report();
  end
endmodule
